//--- design/ssr_pkg.sv
/*
 * Shared constants for the status-reporting block: bit positions of the
 * status byte and the standard event latch, read and write selector codes,
 * error codes and reset values.
 * Assumes every user sits on the single system clock.
 */
`default_nettype none

package ssr_pkg;
    localparam int          ERR_DEPTH   = 10;
    localparam int          EVT_W       = 16;
    localparam int          DATA_W      = 16;

    // Status byte bit positions.
    localparam int          SB_ERRQ     = 2;
    localparam int          SB_QUES     = 3;
    localparam int          SB_MAV      = 4;
    localparam int          SB_ESB      = 5;
    localparam int          SB_MSS      = 6;
    localparam logic [7:0]  SB_SUM_MASK = 8'h3c;

    // Standard event latch bit positions.
    localparam int          ESR_OPC     = 0;
    localparam int          ESR_QYE     = 2;
    localparam int          ESR_DDE     = 3;
    localparam int          ESR_EXE     = 4;
    localparam int          ESR_CME     = 5;
    localparam int          ESR_PON     = 7;
    localparam logic [7:0]  ESR_USED    = 8'hbd;
    localparam logic [7:0]  ESR_RESET   = 8'h80;

    // Read selector codes.
    localparam logic [3:0]  RD_STB      = 4'h0;
    localparam logic [3:0]  RD_SPOLL    = 4'h1;
    localparam logic [3:0]  RD_ESR      = 4'h2;
    localparam logic [3:0]  RD_ESE      = 4'h3;
    localparam logic [3:0]  RD_SRE      = 4'h4;
    localparam logic [3:0]  RD_OPER     = 4'h5;
    localparam logic [3:0]  RD_OPER_EN  = 4'h6;
    localparam logic [3:0]  RD_MEAS     = 4'h7;
    localparam logic [3:0]  RD_MEAS_EN  = 4'h8;
    localparam logic [3:0]  RD_QUES     = 4'h9;
    localparam logic [3:0]  RD_QUES_EN  = 4'ha;
    localparam logic [3:0]  RD_ERR      = 4'hb;

    // Write selector codes.
    localparam logic [2:0]  WR_SRE      = 3'h0;
    localparam logic [2:0]  WR_ESE      = 3'h1;
    localparam logic [2:0]  WR_OPER_EN  = 3'h2;
    localparam logic [2:0]  WR_MEAS_EN  = 3'h3;
    localparam logic [2:0]  WR_QUES_EN  = 3'h4;

    // Error codes as 16-bit two's complement.
    localparam logic [15:0] ERR_NONE    = 16'h0000;
    localparam logic [15:0] ERR_QOVF    = 16'hfeb6;

    typedef enum logic {
        OPC_IDLE,
        OPC_WAIT
    } ssr_opc_state_t;
endpackage

`default_nettype wire

//--- design/ssr_err_if.sv
/*
 * Carrier between the status core and its error queue.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface ssr_err_if;
    logic        push;
    logic [15:0] code;
    logic        pop;
    logic        clear;
    logic        empty;
    logic [15:0] head;

    modport core  (output push, code, pop, clear, input  empty, head);
    modport queue (input  push, code, pop, clear, output empty, head);
endinterface

`default_nettype wire

//--- design/ssr_err_queue.sv
/*
 * Error queue: first-in first-out store of error codes with an overflow
 * marker. Assumes push, pop and clear are one-cycle pulses on i_clk.
 */
`default_nettype none

module ssr_err_queue #(
    parameter int DEPTH = ssr_pkg::ERR_DEPTH
) (
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    ssr_err_if.queue   eq
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [15:0]   mem [DEPTH];
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [CW-1:0] count;
    logic          ovf;

    function automatic logic [PW-1:0] fn_inc(input logic [PW-1:0] p);
        fn_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    wire logic          full    = (count == CW'(DEPTH));
    wire logic          do_pop  = eq.pop & (count != '0);
    wire logic          do_push = eq.push & ~ovf & (~full | do_pop);
    wire logic          do_ovf  = eq.push & ~ovf & full & ~do_pop;
    wire logic [PW-1:0] last    = (wr_ptr == '0) ? PW'(DEPTH - 1) : wr_ptr - 1'b1;
    // An error that meets a clear opens the emptied queue instead of being lost.
    wire logic          fresh   = eq.push & eq.clear & ~i_rst;

    assign eq.empty = (count == '0);
    assign eq.head  = mem[rd_ptr];

    // Once the marker is in, every later error is dropped until a clear,
    // so the host sees where the history was cut.
    always_ff @(posedge i_clk) begin
        if (i_rst | eq.clear) begin
            rd_ptr <= '0;
            wr_ptr <= PW'(fresh);
            count  <= CW'(fresh);
            ovf    <= 1'b0;
            if (fresh) begin
                mem[0] <= eq.code;
            end
        end else begin
            if (do_push) begin
                mem[wr_ptr] <= eq.code;
                wr_ptr      <= fn_inc(wr_ptr);
            end
            if (do_ovf) begin
                mem[last] <= ssr_pkg::ERR_QOVF;
                ovf       <= 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= fn_inc(rd_ptr);
            end
            if (do_push & ~do_pop) begin
                count <= count + 1'b1;
            end else if (~do_push & do_pop) begin
                count <= count - 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_clear_empties: assert property (
        eq.clear && !eq.push |=> eq.empty && !ovf)
        else $error("error queue not empty after clear");
    a_clear_keeps: assert property (
        eq.clear && eq.push |=> count == CW'(1) && eq.head == $past(eq.code))
        else $error("error pushed with clear was lost");
    a_ovf_blocks: assert property (
        ovf && eq.push && !eq.pop && !eq.clear |=> count == $past(count))
        else $error("error accepted after overflow");
    a_ovf_marks: assert property (
        do_ovf && !eq.clear |=> ovf && mem[$past(last)] == ssr_pkg::ERR_QOVF)
        else $error("overflow marker missing");
    a_pop_order: assert property (
        do_pop && !eq.clear |=> rd_ptr == fn_inc($past(rd_ptr)))
        else $error("read pointer did not advance");
endmodule

`default_nettype wire

//--- design/ssr_status_core.sv
/*
 * Status-reporting core: event latches with enable masks for the standard,
 * operation, measurement and questionable groups, the status byte with
 * master summary and service request, operation-complete tracking and the
 * error queue. Assumes a command parser on the same clock that issues
 * one-cycle strobes and selector codes; no input needs synchronising.
 */
`default_nettype none

module ssr_status_core #(
    parameter int ERR_DEPTH = ssr_pkg::ERR_DEPTH
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wr_req,
    input  wire logic [2:0]  i_wr_sel,
    input  wire logic [15:0] i_wr_data,
    input  wire logic        i_rd_req,
    input  wire logic [3:0]  i_rd_sel,
    input  wire logic        i_cmd_cls,
    input  wire logic        i_cmd_rst,
    input  wire logic        i_cmd_sys_clear,
    input  wire logic        i_cmd_opc,
    input  wire logic        i_cmd_opc_query,
    input  wire logic        i_ops_pending,
    input  wire logic [15:0] i_evt_oper,
    input  wire logic [15:0] i_evt_meas,
    input  wire logic [15:0] i_evt_ques,
    input  wire logic        i_dev_err,
    input  wire logic        i_exec_err,
    input  wire logic        i_syntax_err,
    input  wire logic        i_outq_read_empty,
    input  wire logic        i_inbuf_full,
    input  wire logic        i_outbuf_full,
    input  wire logic        i_outq_avail,
    input  wire logic        i_err_push,
    input  wire logic [15:0] i_err_code,
    output logic      [15:0] o_rd_data,
    output logic             o_rd_valid,
    output logic      [7:0]  o_status_byte,
    output logic             o_srq,
    output logic             o_opc_done
);
    localparam int EW = ssr_pkg::EVT_W;

    logic [7:0]                  esr;
    logic [7:0]                  ese;
    logic [7:0]                  sre;
    logic [EW-1:0]               oper;
    logic [EW-1:0]               oper_en;
    logic [EW-1:0]               meas;
    logic [EW-1:0]               meas_en;
    logic [EW-1:0]               ques;
    logic [EW-1:0]               ques_en;
    ssr_pkg::ssr_opc_state_t     opc_st;
    ssr_pkg::ssr_opc_state_t     opcq_st;
    ssr_pkg::ssr_opc_state_t     next_opc_st;
    ssr_pkg::ssr_opc_state_t     next_opcq_st;

    ssr_err_if eif ();

    ssr_err_queue #(
        .DEPTH (ERR_DEPTH)
    ) u_errq (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .eq    (eif)
    );

    // New event bits win over a clear in the same cycle, so nothing is lost.
    function automatic logic [EW-1:0] fn_latch(
        input logic [EW-1:0] cur,
        input logic          clr,
        input logic [EW-1:0] evt,
        input logic [EW-1:0] en
    );
        fn_latch = (clr ? '0 : cur) | (evt & en);
    endfunction

    function automatic logic fn_rd(input logic [3:0] sel);
        fn_rd = i_rd_req & (i_rd_sel == sel);
    endfunction

    function automatic logic fn_wr(input logic [2:0] sel);
        fn_wr = i_wr_req & (i_wr_sel == sel);
    endfunction

    // Read and write decode.
    wire logic rd_esr   = fn_rd(ssr_pkg::RD_ESR);
    wire logic rd_oper  = fn_rd(ssr_pkg::RD_OPER);
    wire logic rd_meas  = fn_rd(ssr_pkg::RD_MEAS);
    wire logic rd_ques  = fn_rd(ssr_pkg::RD_QUES);
    wire logic rd_err   = fn_rd(ssr_pkg::RD_ERR);
    wire logic rd_spoll = fn_rd(ssr_pkg::RD_SPOLL);
    wire logic wr_sre   = fn_wr(ssr_pkg::WR_SRE);
    wire logic wr_ese   = fn_wr(ssr_pkg::WR_ESE);
    wire logic wr_oen   = fn_wr(ssr_pkg::WR_OPER_EN);
    wire logic wr_men   = fn_wr(ssr_pkg::WR_MEAS_EN);
    wire logic wr_qen   = fn_wr(ssr_pkg::WR_QUES_EN);

    // Completion fires at the earliest the cycle after the command, which
    // covers the command's own execution.
    wire logic opc_fire  = (opc_st == ssr_pkg::OPC_WAIT) & ~i_ops_pending;
    wire logic opcq_fire = (opcq_st == ssr_pkg::OPC_WAIT) & ~i_ops_pending;
    wire logic opc_abort = i_cmd_cls | i_cmd_rst;

    wire logic qry_err = i_outq_read_empty | (i_inbuf_full & i_outbuf_full);

    wire logic [7:0] std_evt = {
        1'b0, 1'b0, i_syntax_err, i_exec_err, i_dev_err, qry_err, 1'b0, opc_fire
    };

    // The reset command is deliberately absent from every clear term.
    wire logic [7:0] next_esr = ssr_pkg::ESR_USED & 8'(fn_latch(
        EW'(esr), i_cmd_cls | rd_esr, EW'(std_evt), EW'(ese)));
    wire logic [EW-1:0] next_oper = fn_latch(oper, i_cmd_cls | rd_oper, i_evt_oper, oper_en);
    wire logic [EW-1:0] next_meas = fn_latch(meas, i_cmd_cls | rd_meas, i_evt_meas, meas_en);
    wire logic [EW-1:0] next_ques = fn_latch(ques, i_cmd_cls | rd_ques, i_evt_ques, ques_en);

    wire logic [7:0] next_ese = wr_ese ? i_wr_data[7:0] : ese;
    wire logic [7:0] next_sre = wr_sre ? i_wr_data[7:0] : sre;

    // Summaries are built from next values (the questionable one with the current ques_en) so the status byte agrees with
    // the latches on the same edge; a cleared group drops its bit at once.
    wire logic esb_sum  = |(next_esr & next_ese);
    wire logic ques_sum = |(next_ques & ques_en);
    // A clear drops the queue bit at once; a push that meets it keeps one entry.
    wire logic errq_sum = (~eif.empty & ~eif.clear) | eif.push;

    wire logic [7:0] sb_low = {
        2'b00, esb_sum, i_outq_avail, ques_sum, errq_sum, 2'b00
    };
    wire logic mss = |(sb_low & next_sre & ssr_pkg::SB_SUM_MASK);
    wire logic [7:0] next_stb = sb_low | {1'b0, mss, 6'b000000};

    // Request rises with the master summary and drops with it; a serial
    // poll also withdraws it, the status query does not.
    wire logic mss_rise  = mss & ~o_status_byte[ssr_pkg::SB_MSS];
    wire logic next_srq  = mss & (mss_rise | (o_srq & ~rd_spoll));

    wire logic [15:0] err_word = eif.empty ? ssr_pkg::ERR_NONE : eif.head;

    // Reads return the binary-weighted contents before any clear.
    wire logic [15:0] rd_mux =
        (i_rd_sel == ssr_pkg::RD_STB)     ? {8'h00, o_status_byte} :
        (i_rd_sel == ssr_pkg::RD_SPOLL)   ? {8'h00, o_status_byte} :
        (i_rd_sel == ssr_pkg::RD_ESR)     ? {8'h00, esr} :
        (i_rd_sel == ssr_pkg::RD_ESE)     ? {8'h00, ese} :
        (i_rd_sel == ssr_pkg::RD_SRE)     ? {8'h00, sre} :
        (i_rd_sel == ssr_pkg::RD_OPER)    ? oper :
        (i_rd_sel == ssr_pkg::RD_OPER_EN) ? oper_en :
        (i_rd_sel == ssr_pkg::RD_MEAS)    ? meas :
        (i_rd_sel == ssr_pkg::RD_MEAS_EN) ? meas_en :
        (i_rd_sel == ssr_pkg::RD_QUES)    ? ques :
        (i_rd_sel == ssr_pkg::RD_QUES_EN) ? ques_en :
        (i_rd_sel == ssr_pkg::RD_ERR)     ? err_word : 16'h0000;

    assign eif.push  = i_err_push;
    assign eif.code  = i_err_code;
    assign eif.pop   = rd_err;
    assign eif.clear = i_cmd_sys_clear | i_cmd_cls;

    always_comb begin
        next_opc_st = opc_st;
        case (opc_st)
            ssr_pkg::OPC_IDLE: if (i_cmd_opc) next_opc_st = ssr_pkg::OPC_WAIT;
            ssr_pkg::OPC_WAIT: if (opc_fire) next_opc_st = ssr_pkg::OPC_IDLE;
            default:           next_opc_st = ssr_pkg::OPC_IDLE;
        endcase
        if (opc_abort) begin
            next_opc_st = ssr_pkg::OPC_IDLE;
        end
    end

    always_comb begin
        next_opcq_st = opcq_st;
        case (opcq_st)
            ssr_pkg::OPC_IDLE: if (i_cmd_opc_query) next_opcq_st = ssr_pkg::OPC_WAIT;
            ssr_pkg::OPC_WAIT: if (opcq_fire) next_opcq_st = ssr_pkg::OPC_IDLE;
            default:           next_opcq_st = ssr_pkg::OPC_IDLE;
        endcase
        if (opc_abort) begin
            next_opcq_st = ssr_pkg::OPC_IDLE;
        end
    end

    // Power-up leaves the power-on bit set; that is the only way it is made.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            esr <= ssr_pkg::ESR_RESET;
            ese <= 8'h00;
            sre <= 8'h00;
        end else begin
            esr <= next_esr;
            ese <= next_ese;
            sre <= next_sre;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            oper    <= '0;
            meas    <= '0;
            ques    <= '0;
            oper_en <= '0;
            meas_en <= '0;
            ques_en <= '0;
        end else begin
            oper    <= next_oper;
            meas    <= next_meas;
            ques    <= next_ques;
            oper_en <= wr_oen ? i_wr_data : oper_en;
            meas_en <= wr_men ? i_wr_data : meas_en;
            ques_en <= wr_qen ? i_wr_data : ques_en;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            opc_st        <= ssr_pkg::OPC_IDLE;
            opcq_st       <= ssr_pkg::OPC_IDLE;
            o_status_byte <= 8'h00;
            o_srq         <= 1'b0;
            o_opc_done    <= 1'b0;
            o_rd_data     <= 16'h0000;
            o_rd_valid    <= 1'b0;
        end else begin
            opc_st        <= next_opc_st;
            opcq_st       <= next_opcq_st;
            o_status_byte <= next_stb;
            o_srq         <= next_srq;
            o_opc_done    <= opcq_fire & ~opc_abort;
            o_rd_data     <= i_rd_req ? rd_mux : o_rd_data;
            o_rd_valid    <= i_rd_req;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_opc_armed;
        i_cmd_opc && !opc_abort ##1 opc_st == ssr_pkg::OPC_WAIT;
    endsequence

    sequence s_opcq_armed;
        i_cmd_opc_query && !opc_abort ##1 opcq_st == ssr_pkg::OPC_WAIT;
    endsequence

    a_esr_holds: assert property (
        std_evt == 8'h00 && !i_cmd_cls && !rd_esr |=> esr == $past(esr))
        else $error("standard event latch changed without cause");
    a_esr_read_clear: assert property (
        rd_esr && std_evt == 8'h00 |=> esr == 8'h00 && o_rd_data == {8'h00, $past(esr)})
        else $error("standard event read did not return then clear");
    a_rst_keeps: assert property (
        i_cmd_rst && !i_cmd_cls && !rd_ques |=> ques == ($past(ques) | $past(i_evt_ques & ques_en)))
        else $error("reset command disturbed an event latch");
    a_gate_enable: assert property (
        1'b1 |=> ((esr & ~$past(esr)) & ~$past(ese)) == 8'h00)
        else $error("disabled standard event latched");
    a_mask_keep: assert property (
        !wr_ese && !wr_qen |=> ese == $past(ese) && ques_en == $past(ques_en))
        else $error("enable mask changed without a write");
    a_cls_masks: assert property (
        i_cmd_cls && !i_wr_req && std_evt == 8'h00 |=> esr == 8'h00 && ese == $past(ese))
        else $error("clear-status mishandled latch or mask");
    a_mav_bit: assert property (
        1'b1 |=> o_status_byte[ssr_pkg::SB_MAV] == $past(i_outq_avail))
        else $error("message available bit wrong");
    a_sb_zeros: assert property (
        o_status_byte[1:0] == 2'b00 && !o_status_byte[7]
        && o_status_byte[ssr_pkg::SB_ESB] == |(esr & ese))
        else $error("status byte fixed or summary bits wrong");
    a_mss_bit: assert property (
        o_status_byte[ssr_pkg::SB_MSS] == |(o_status_byte & sre & ssr_pkg::SB_SUM_MASK))
        else $error("master summary bit wrong");
    a_opc_sets: assert property (
        s_opc_armed ##0 !i_ops_pending && ese[ssr_pkg::ESR_OPC] && !opc_abort
        |=> esr[ssr_pkg::ESR_OPC])
        else $error("completion bit not set");
    a_opcq_done: assert property (
        s_opcq_armed ##0 !i_ops_pending && !opc_abort |=> o_opc_done)
        else $error("completion answer missing");
    a_srq_rise: assert property (
        $rose(o_status_byte[ssr_pkg::SB_MSS]) |-> o_srq)
        else $error("service request missing on master summary");
    a_srq_drop: assert property (
        !o_status_byte[ssr_pkg::SB_MSS] |-> !o_srq)
        else $error("service request without master summary");
    a_poll_drops: assert property (
        rd_spoll && o_status_byte[ssr_pkg::SB_MSS] |=> !o_srq)
        else $error("serial poll left service request");
    a_stb_keeps: assert property (
        i_rd_req && i_rd_sel == ssr_pkg::RD_STB && o_srq && mss |=> o_srq)
        else $error("status query dropped service request");
    a_sre_zero: assert property (
        wr_sre && i_wr_data[7:0] == 8'h00 |=> sre == 8'h00 && !o_status_byte[ssr_pkg::SB_MSS])
        else $error("status enable mask not cleared");
    a_qry_err: assert property (
        (i_outq_read_empty || (i_inbuf_full && i_outbuf_full)) && ese[ssr_pkg::ESR_QYE]
        |=> esr[ssr_pkg::ESR_QYE])
        else $error("query error bit not set");
    a_exec_err: assert property (
        i_exec_err && ese[ssr_pkg::ESR_EXE] |=> esr[ssr_pkg::ESR_EXE])
        else $error("execution error bit not set");
    a_esr_unused: assert property (
        !esr[1] && !esr[6])
        else $error("unused standard event bit set");
    a_pon_reset: assert property (
        $fell(i_rst) |-> esr[ssr_pkg::ESR_PON])
        else $error("power-on bit missing after reset");
    a_ques_clear: assert property (
        rd_ques && i_evt_ques == 16'h0000 |=> !o_status_byte[ssr_pkg::SB_QUES])
        else $error("questionable summary kept after clear");
    a_err_none: assert property (
        rd_err && eif.empty |=> o_rd_data == ssr_pkg::ERR_NONE)
        else $error("empty error queue did not read as no error");
    a_ese_read: assert property (
        i_rd_req && i_rd_sel == ssr_pkg::RD_ESE |=> o_rd_data == {8'h00, $past(ese)})
        else $error("enable mask read wrong");
endmodule

`default_nettype wire

//--- test/ssr_host_model.sv
/*
 * Remote host model: issues register writes and reads to the status core.
 * Assumes the core takes requests on the rising edge of i_clk.
 */
`default_nettype none

module ssr_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_valid,
    output logic             o_wr_req,
    output logic      [2:0]  o_wr_sel,
    output logic      [15:0] o_wr_data,
    output logic             o_rd_req,
    output logic      [3:0]  o_rd_sel
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {o_wr_req, o_wr_sel, o_wr_data, o_rd_req, o_rd_sel} = '0;
    end

    // The released data line gets the inverse value so a stale word is never mistaken.
    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        @(negedge i_clk);
        o_wr_req  <= 1'b1;
        o_wr_sel  <= s;
        o_wr_data <= d;
        @(negedge i_clk);
        o_wr_req  <= 1'b0;
        o_wr_data <= ~d;
    endtask

    task automatic rd(input logic [3:0] s, output logic [15:0] d, output logic v);
        @(negedge i_clk);
        o_rd_req <= 1'b1;
        o_rd_sel <= s;
        @(negedge i_clk);
        d = i_rd_data;
        v = i_rd_valid;
        o_rd_req <= 1'b0;
        o_rd_sel <= ~s;
    endtask
endmodule

`default_nettype wire

//--- test/scpi_status_reporting_test.sv
/*
 * Self-checking bench for the status core, with a queue-based model.
 * Assumes the host model drives the register strobes.
 */
`default_nettype none

module scpi_status_reporting_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic        i_clk = 1'b0;
    logic        i_rst, i_wr_req, i_rd_req, i_ops_pending, i_inbuf_full, i_outbuf_full;
    logic        i_outq_avail, i_err_push, o_rd_valid, o_srq, o_opc_done;
    logic        i_cmd_cls, i_cmd_rst, i_cmd_sys_clear, i_cmd_opc, i_cmd_opc_query;
    logic        i_dev_err, i_exec_err, i_syntax_err, i_outq_read_empty;
    logic [2:0]  i_wr_sel;
    logic [3:0]  i_rd_sel;
    logic [8:0]  cmds;
    logic [47:0] evts;
    logic [15:0] i_wr_data, i_evt_oper, i_evt_meas, i_evt_ques, i_err_code, o_rd_data;
    logic [7:0]  o_status_byte;
    int          err_total, checked, esr, ese, sre, en[3], ev[3], errq[$], done_cnt;
    bit          ovf, polled;

    assign {i_outq_read_empty, i_syntax_err, i_exec_err, i_dev_err, i_cmd_opc_query,
            i_cmd_opc, i_cmd_sys_clear, i_cmd_rst, i_cmd_cls} = cmds;
    assign {i_evt_ques, i_evt_meas, i_evt_oper} = evts;

    ssr_status_core ssr_status_core_i (
        .i_clk, .i_rst, .i_wr_req, .i_wr_sel, .i_wr_data, .i_rd_req, .i_rd_sel,
        .i_cmd_cls, .i_cmd_rst, .i_cmd_sys_clear, .i_cmd_opc, .i_cmd_opc_query,
        .i_ops_pending, .i_evt_oper, .i_evt_meas, .i_evt_ques, .i_dev_err,
        .i_exec_err, .i_syntax_err, .i_outq_read_empty, .i_inbuf_full,
        .i_outbuf_full, .i_outq_avail, .i_err_push, .i_err_code, .o_rd_data,
        .o_rd_valid, .o_status_byte, .o_srq, .o_opc_done
    );
    ssr_host_model ssr_host_model_i (
        .i_clk, .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid), .o_wr_req(i_wr_req),
        .o_wr_sel(i_wr_sel), .o_wr_data(i_wr_data), .o_rd_req(i_rd_req), .o_rd_sel(i_rd_sel)
    );

    always #25 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (o_opc_done === 1'b1) done_cnt++;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input int e, input logic [15:0] g);
        checked++;
        if (g !== e[15:0]) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e[15:0], g);
        end
    endtask

    function automatic int sbm();
        int s;
        s = (errq.size() != 0 ? 4 : 0) + ((ev[2] & en[2]) != 0 ? 8 : 0)
            + (i_outq_avail === 1'b1 ? 16 : 0) + ((esr & ese) != 0 ? 32 : 0);
        if ((s & sre & 'h3c) != 0) s += 64;
        return s;
    endfunction

    task automatic sbc();
        int s;
        repeat (2) @(negedge i_clk);
        s = sbm();
        if (s[6] == 1'b0) polled = 1'b0;
        chk("status_byte", s, {8'h0, o_status_byte});
        chk("srq", (s[6] && !polled) ? 1 : 0, {15'h0, o_srq});
    endtask

    task automatic rq(input logic [3:0] s);
        int          e;
        logic [15:0] d;
        logic        v;
        case (s)
            4'h2: e = esr;
            4'h3: e = ese;
            4'h4: e = sre;
            4'h5, 4'h7, 4'h9: e = ev[(s - 5) / 2];
            4'h6, 4'h8, 4'ha: e = en[(s - 6) / 2];
            4'hb: e = (errq.size() != 0) ? errq[0] : 0;
            4'hc: e = 0;
            default: e = sbm();
        endcase
        ssr_host_model_i.rd(s, d, v);
        chk("rd_valid", 1, {15'h0, v});
        chk("rd_data", e, d);
        if (s == 4'h2) esr = 0;
        if (s == 4'h1) polled = 1'b1;
        if (s inside {4'h5, 4'h7, 4'h9}) ev[(s - 5) / 2] = 0;
        if (s == 4'hb && errq.size() != 0) void'(errq.pop_front());
    endtask

    task automatic w(input logic [2:0] s, input logic [15:0] d);
        ssr_host_model_i.wr(s, d);
        if (s == 3'h0) sre = d[7:0];
        else if (s == 3'h1) ese = d[7:0];
        else en[s - 2] = d;
    endtask

    task automatic pz(input logic [8:0] p);
        @(negedge i_clk);
        cmds <= p;
        esr |= {p[7:5], p[8], 2'b0} & ese;
        if (p[0] || p[2]) begin
            errq.delete();
            ovf = 1'b0;
        end
        if (p[0]) begin
            esr = 0;
            ev = '{0, 0, 0};
        end
        @(negedge i_clk);
        cmds <= 9'h0;
    endtask

    task automatic evx(input logic [47:0] x);
        @(negedge i_clk);
        evts <= x;
        for (int g = 0; g < 3; g++) ev[g] |= x[g * 16 +: 16] & en[g];
        @(negedge i_clk);
        evts <= 48'h0;
    endtask

    // Once overflowed, the model drops pushes until a clear, as the core must.
    task automatic ep(input logic [15:0] c);
        @(negedge i_clk);
        i_err_push <= 1'b1;
        i_err_code <= c;
        if (!ovf && errq.size() < ssr_pkg::ERR_DEPTH) errq.push_back(c);
        else if (!ovf) begin
            errq[ssr_pkg::ERR_DEPTH - 1] = ssr_pkg::ERR_QOVF;
            ovf = 1'b1;
        end
        @(negedge i_clk);
        i_err_push <= 1'b0;
        i_err_code <= ~c;
    endtask

    initial begin
        #(4000 * 50);
        err_total++;
        test_done();
    end

    initial begin
        {i_rst, i_ops_pending, i_inbuf_full, i_outbuf_full, i_outq_avail} = 5'h10;
        {i_err_push, i_err_code, cmds, evts} = '0;
        void'($urandom(70));
        esr = 'h80;
        repeat (10) @(negedge i_clk);
        i_rst <= 1'b0;
        rq(4'h2);
        rq(4'h2);
        rq(4'hc);
        for (int g = 0; g < 3; g++) begin
            w(3'(g + 2), 16'($urandom));
            rq(4'(2 * g + 6));
            rq(4'(2 * g + 6));
        end
        evx(48'({$urandom, $urandom}));
        sbc();
        pz(9'h002);
        rq(4'h5);
        rq(4'h9);
        sbc();
        evx(48'({$urandom, $urandom}));
        pz(9'h001);
        rq(4'ha);
        rq(4'h7);
        w(3'h1, 16'($urandom) | 16'h0004);
        @(negedge i_clk);
        {i_inbuf_full, i_outbuf_full} <= 2'b11;
        esr |= 4 & ese;
        @(negedge i_clk);
        {i_inbuf_full, i_outbuf_full} <= 2'b00;
        rq(4'h2);
        pz(9'h1e0);
        rq(4'h2);
        w(3'h1, 16'h00ff);
        rq(4'h3);
        pz(9'h080);
        sbc();
        w(3'h0, 16'h0020);
        rq(4'h4);
        sbc();
        rq(4'h0);
        sbc();
        rq(4'h1);
        sbc();
        w(3'h0, 16'h0000);
        sbc();
        i_outq_avail <= 1'b1;
        sbc();
        i_outq_avail <= 1'b0;
        sbc();
        for (int k = 0; k < 12; k++) ep(16'($urandom));
        sbc();
        repeat (11) rq(4'hb);
        ep(16'h1234);
        rq(4'hb);
        pz(9'h004);
        ep(16'h0101);
        ep(16'h0202);
        pz(9'h002);
        rq(4'hb);
        pz(9'h004);
        rq(4'hb);
        w(3'h1, 16'h0001);
        i_ops_pending <= 1'b1;
        pz(9'h008);
        repeat (4) @(negedge i_clk);
        rq(4'h2);
        i_ops_pending <= 1'b0;
        repeat (3) @(negedge i_clk);
        esr |= 1;
        rq(4'h2);
        pz(9'h010);
        repeat (3) @(negedge i_clk);
        chk("opc_done", 1, 16'(done_cnt));
        test_done();
    end
endmodule

`default_nettype wire
